// ===== hdl/unbl_baud.v
// Baud divider giving a one-cycle enable at sixteen times the bit rate.
`timescale 1ns/10ps
module unbl_baud (
   input  wire        clk,
   input  wire        rst,
   input  wire        run_en,
   input  wire [15:0] divisor,
   output reg         tick
);
   reg [15:0] count;

   always @(posedge clk) begin
      if (rst) begin
         count <= 16'h0000;
         tick  <= 1'b0;
      end else if (!run_en) begin
         tick <= 1'b0;
      end else if (count + 16'h0001 >= divisor) begin
         count <= 16'h0000;
         tick  <= 1'b1;
      end else begin
         count <= count + 16'h0001;
         tick  <= 1'b0;
      end
   end
endmodule

// ===== hdl/unbl_fifo2.v
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/10ps
module unbl_fifo2 #(
   parameter W = 8
) (
   input  wire         clk,
   input  wire         rst,
   input  wire         in_valid,
   output wire         in_ready,
   input  wire [W-1:0] in_data,
   output wire         out_valid,
   input  wire         out_ready,
   output wire [W-1:0] out_data
);
   reg [W-1:0] mem0;
   reg [W-1:0] mem1;
   reg [1:0]   fill;
   wire        push;
   wire        pop;

   assign in_ready  = (fill != 2'd2);
   assign out_valid = (fill != 2'd0);
   assign out_data  = mem0;
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge clk) begin
      if (rst) begin
         fill <= 2'd0;
         mem0 <= {W{1'b0}};
         mem1 <= {W{1'b0}};
      end else begin
         if (pop) begin
            mem0 <= (push && fill == 2'd1) ? in_data : mem1;
         end else if (push && fill == 2'd0) begin
            mem0 <= in_data;
         end
         if (push && ((fill == 2'd1 && !pop) || fill == 2'd2)) begin
            mem1 <= in_data;
         end
         if (push && !pop) begin
            fill <= fill + 2'd1;
         end else if (pop && !push) begin
            fill <= fill - 2'd1;
         end
      end
   end
endmodule

// ===== hdl/unbl_map.vh
// Register map, field positions, reset values and timing counts.
`ifndef UNBL_MAP_VH
`define UNBL_MAP_VH
`define UNBL_OFS_DATA     8'h00
`define UNBL_OFS_CTRL1    8'h04
`define UNBL_OFS_CTRL3    8'h08
`define UNBL_OFS_STATUS   8'h0C
`define UNBL_OFS_BAUD     8'h10
`define UNBL_C1_NINE      0
`define UNBL_C1_LOOP      1
`define UNBL_C1_RECEIVER_SOURCE_SELECT      2
`define UNBL_C1_ADDRWAKE  3
`define UNBL_C1_SLEEP     4
`define UNBL_C1_TXEN      5
`define UNBL_C1_RXEN      6
`define UNBL_C3_T9        0
`define UNBL_C3_R9        1
`define UNBL_C3_DIR       2
`define UNBL_C3_EDGEIE    3
`define UNBL_ST_TXROOM    0
`define UNBL_ST_TXDONE    1
`define UNBL_ST_RXFULL    2
`define UNBL_ST_EDGE      3
`define UNBL_ST_IDLE      4
`define UNBL_ST_OVR       5
`define UNBL_ST_FRM       6
`define UNBL_CTRL1_RST    7'h00
`define UNBL_CTRL3_RST    4'h0
`define UNBL_BAUD_RST     16'h0015
`define UNBL_TICKS_BIT    5'd16
`define UNBL_IDLE_BITS8   8'd10
`define UNBL_IDLE_BITS9   8'd11
`define UNBL_FRAME_BITS8  4'd10
`define UNBL_FRAME_BITS9  4'd11
`define UNBL_STOP_RUN     2'b00
`define UNBL_STOP_LIGHT   2'b01
`endif

// ===== hdl/unbl_top.v
// Serial port with nine-bit characters, stop handling, loop and single wire.
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`include "unbl_map.vh"
module unbl_top (
   input  wire        clk,
   input  wire        sys_rst,
   input  wire [7:0]  paddr,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire [1:0]  stop_mode,
   input  wire        rxd_in,
   input  wire        txd_in,
   output reg         txd_out,
   output reg         txd_oe,
   output reg         rxd_release,
   output reg         wake_req
);
   // ==========================================================
   // Stop handling.
   wire        rst_all;
   wire        run_en;
   wire        edge_en;
   // ==========================================================
   // Registers.
   reg  [6:0]  ctrl1;
   reg  [3:0]  ctrl3;
   reg  [15:0] baud_div;
   reg         rx_ninth_bit;
   reg  [7:0]  rx_data;
   reg         rx_full;
   reg         edge_flag;
   reg         idle_flag;
   reg         ovr_flag;
   reg         frm_flag;
   wire        nine_bit_sel;
   wire        loop_select;
   wire        receiver_source_select;
   wire        single_wire_direction;
   wire        rx_edge_irq_enable;
   wire        tx_ninth_bit;
   wire        acc;
   wire        wr_fire;
   wire        rd_fire;
   wire        w1c_ok;
   reg  [31:0] rd_mux;
   reg         bad_addr;
   // ==========================================================
   // Datapath.
   wire        tick;
   wire        fifo_in_ready;
   wire        fifo_out_valid;
   wire [7:0]  fifo_out_data;
   wire        tx_load;
   reg  [10:0] tx_sh;
   reg  [3:0]  tx_cnt;
   reg  [3:0]  tx_ph;
   reg         tx_busy;
   reg         tx_line;
   reg         rx_src;
   reg         rx_prev;
   reg         rx_busy;
   reg  [3:0]  rx_ph;
   reg  [3:0]  rx_cnt;
   reg  [8:0]  rx_sh;
   reg  [7:0]  idle_cnt;
   reg         idle_armed;
   wire [3:0]  rx_nbits;
   wire [7:0]  idle_limit;
   wire        rx_done;
   wire        rx_mark;
   wire        rx_keep;
   wire        idle_hit;

   // Deep stops act as a reset; light stop freezes the serial logic except the edge detector.
   assign rst_all = sys_rst | stop_mode[1];
   assign run_en  = (stop_mode == `UNBL_STOP_RUN);
   assign edge_en = (stop_mode == `UNBL_STOP_RUN ||
                     stop_mode == `UNBL_STOP_LIGHT) &&
                    ctrl1[`UNBL_C1_RXEN];

   assign nine_bit_sel           = ctrl1[`UNBL_C1_NINE];
   assign loop_select            = ctrl1[`UNBL_C1_LOOP];
   assign receiver_source_select = ctrl1[`UNBL_C1_RECEIVER_SOURCE_SELECT];
   assign single_wire_direction  = ctrl3[`UNBL_C3_DIR];
   assign rx_edge_irq_enable     = ctrl3[`UNBL_C3_EDGEIE];
   assign tx_ninth_bit           = ctrl3[`UNBL_C3_T9];

   // ==========================================================
   // APB slave.
   assign acc     = psel & penable;
   assign wr_fire = acc & pready & pwrite;
   assign rd_fire = acc & pready & ~pwrite;
   assign w1c_ok  = wr_fire && paddr == `UNBL_OFS_STATUS;

   always @* begin
      rd_mux   = 32'h0000_0000;
      bad_addr = 1'b0;
      case (paddr)
         `UNBL_OFS_DATA: begin
            rd_mux[7:0] = rx_data;
         end
         `UNBL_OFS_CTRL1: begin
            rd_mux[6:0] = ctrl1;
         end
         `UNBL_OFS_CTRL3: begin
            rd_mux[3:0]         = ctrl3;
            rd_mux[`UNBL_C3_R9] = rx_ninth_bit;
         end
         `UNBL_OFS_STATUS: begin
            rd_mux[`UNBL_ST_TXROOM] = fifo_in_ready;
            rd_mux[`UNBL_ST_TXDONE] = ~tx_busy & ~fifo_out_valid;
            rd_mux[`UNBL_ST_RXFULL] = rx_full;
            rd_mux[`UNBL_ST_EDGE]   = edge_flag;
            rd_mux[`UNBL_ST_IDLE]   = idle_flag;
            rd_mux[`UNBL_ST_OVR]    = ovr_flag;
            rd_mux[`UNBL_ST_FRM]    = frm_flag;
         end
         `UNBL_OFS_BAUD: begin
            rd_mux[15:0] = baud_div;
         end
         default: begin
            bad_addr = 1'b1;
         end
      endcase
   end

   always @(posedge clk) begin
      if (rst_all) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= acc & ~pready;
         prdata  <= rd_mux;
         pslverr <= acc & ~pready & (bad_addr | (pwrite &&
                    paddr == `UNBL_OFS_DATA && !fifo_in_ready));
      end
   end

   // Control registers; all state is held while in light stop.
   always @(posedge clk) begin
      if (rst_all) begin
         ctrl1    <= `UNBL_CTRL1_RST;
         ctrl3    <= `UNBL_CTRL3_RST;
         baud_div <= `UNBL_BAUD_RST;
      end else begin
         if (wr_fire && paddr == `UNBL_OFS_CTRL1) begin
            ctrl1 <= pwdata[6:0];
         end else if (run_en && idle_hit &&
                      !ctrl1[`UNBL_C1_ADDRWAKE]) begin
            ctrl1[`UNBL_C1_SLEEP] <= 1'b0;
         end else if (run_en && rx_done && rx_sh[8] ==
                      1'b1 && ctrl1[`UNBL_C1_ADDRWAKE]) begin
            ctrl1[`UNBL_C1_SLEEP] <= 1'b0;
         end
         if (wr_fire && paddr == `UNBL_OFS_CTRL3) begin
            ctrl3 <= pwdata[3:0];
         end
         if (wr_fire && paddr == `UNBL_OFS_BAUD) begin
            baud_div <= pwdata[15:0];
         end
      end
   end

   // ==========================================================
   // Transmit path: buffer, then shifter.
   unbl_baud u_baud (
      .clk     (clk),
      .rst     (rst_all),
      .run_en  (run_en),
      .divisor (baud_div),
      .tick    (tick)
   );

   unbl_fifo2 #(.W(8)) u_txbuf (
      .clk       (clk),
      .rst       (rst_all),
      .in_valid  (wr_fire && paddr == `UNBL_OFS_DATA),
      .in_ready  (fifo_in_ready),
      .in_data   (pwdata[7:0]),
      .out_valid (fifo_out_valid),
      .out_ready (tx_load),
      .out_data  (fifo_out_data)
   );

   assign tx_load = run_en & fifo_out_valid & ~tx_busy &
                    ctrl1[`UNBL_C1_TXEN];

   always @(posedge clk) begin
      if (rst_all) begin
         tx_sh   <= 11'h7FF;
         tx_cnt  <= 4'd0;
         tx_ph   <= 4'd0;
         tx_busy <= 1'b0;
         tx_line <= 1'b1;
      end else if (tx_load) begin
         // The ninth bit is copied in the same transfer as the data.
         tx_sh   <= {1'b1, nine_bit_sel ? tx_ninth_bit : 1'b1,
                     fifo_out_data, 1'b0};
         tx_cnt  <= nine_bit_sel ? `UNBL_FRAME_BITS9 :
                                   `UNBL_FRAME_BITS8;
         tx_ph   <= 4'd0;
         tx_busy <= 1'b1;
      end else if (run_en && tick && tx_busy) begin
         tx_ph <= tx_ph + 4'd1;
         if (tx_ph == 4'd15) begin
            if (tx_cnt != 4'd0) begin
               tx_line <= tx_sh[0];
               tx_sh   <= {1'b1, tx_sh[10:1]};
               tx_cnt  <= tx_cnt - 4'd1;
            end else begin
               tx_busy <= 1'b0;
            end
         end
      end
   end

   // ==========================================================
   // Pin steering and receiver source selection.
   always @* begin
      if (!loop_select) begin
         rx_src = rxd_in;
      end else if (!receiver_source_select) begin
         rx_src = tx_line;
      end else if (single_wire_direction) begin
         rx_src = tx_line;
      end else begin
         rx_src = txd_in;
      end
   end

   always @(posedge clk) begin
      if (rst_all) begin
         txd_out     <= 1'b1;
         txd_oe      <= 1'b1;
         rxd_release <= 1'b0;
      end else begin
         txd_out     <= tx_line;
         txd_oe      <= ~loop_select | ~receiver_source_select |
                        single_wire_direction;
         rxd_release <= loop_select;
      end
   end

   // ==========================================================
   // Receiver.
   assign rx_nbits   = nine_bit_sel ? 4'd9 : 4'd8;
   assign idle_limit = (nine_bit_sel ? `UNBL_IDLE_BITS9 :
                        `UNBL_IDLE_BITS8) << 4;
   assign rx_done    = run_en & tick & rx_busy & (rx_ph == 4'd15) &
                       (rx_cnt > rx_nbits);
   assign rx_mark    = rx_sh[8];
   assign rx_keep    = ~ctrl1[`UNBL_C1_SLEEP] |
                       (ctrl1[`UNBL_C1_ADDRWAKE] & rx_mark);
   assign idle_hit   = idle_armed & (idle_cnt == idle_limit);

   always @(posedge clk) begin
      if (rst_all) begin
         rx_busy <= 1'b0;
         rx_ph   <= 4'd0;
         rx_cnt  <= 4'd0;
         rx_sh   <= 9'h000;
      end else if (run_en && tick && ctrl1[`UNBL_C1_RXEN]) begin
         if (!rx_busy) begin
            if (!rx_src) begin
               rx_busy <= 1'b1;
               rx_ph   <= 4'd8;
               rx_cnt  <= 4'd0;
            end
         end else begin
            rx_ph <= rx_ph + 4'd1;
            if (rx_ph == 4'd15) begin
               if (rx_cnt == 4'd0 && rx_src) begin
                  rx_busy <= 1'b0;
               end else if (rx_cnt > rx_nbits) begin
                  rx_busy <= 1'b0;
               end else begin
                  rx_cnt <= rx_cnt + 4'd1;
                  if (rx_cnt != 4'd0) begin
                     rx_sh <= {rx_src, rx_sh[8:1]};
                  end
               end
            end
         end
      end
   end

   // Received character store, flags and idle detection.
   always @(posedge clk) begin
      if (rst_all) begin
         rx_data      <= 8'h00;
         rx_ninth_bit <= 1'b0;
         rx_full      <= 1'b0;
         ovr_flag     <= 1'b0;
         frm_flag     <= 1'b0;
         idle_flag    <= 1'b0;
         idle_cnt     <= 8'h00;
         idle_armed   <= 1'b0;
      end else begin
         if (rd_fire && paddr == `UNBL_OFS_DATA) begin
            rx_full <= 1'b0;
         end
         if (w1c_ok && pwdata[`UNBL_ST_OVR]) begin
            ovr_flag <= 1'b0;
         end
         if (w1c_ok && pwdata[`UNBL_ST_FRM]) begin
            frm_flag <= 1'b0;
         end
         if (w1c_ok && pwdata[`UNBL_ST_IDLE]) begin
            idle_flag <= 1'b0;
         end
         if (rx_done && !rx_src) begin
            frm_flag <= 1'b1;
         end else if (rx_done && rx_keep) begin
            idle_armed <= 1'b1;
            if (rx_full && !(rd_fire && paddr == `UNBL_OFS_DATA)) begin
               ovr_flag <= 1'b1;
            end else begin
               rx_full      <= 1'b1;
               rx_data      <= nine_bit_sel ? rx_sh[7:0] : rx_sh[8:1];
               rx_ninth_bit <= nine_bit_sel & rx_sh[8];
            end
         end
         if (run_en && tick) begin
            if (rx_busy || !rx_src) begin
               idle_cnt <= 8'h00;
            end else if (idle_cnt != idle_limit) begin
               idle_cnt <= idle_cnt + 8'h01;
            end
         end
         if (run_en && idle_hit) begin
            idle_flag  <= 1'b1;
            idle_armed <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Active edge detector, alive in run and light stop.
   always @(posedge clk) begin
      if (rst_all) begin
         rx_prev   <= 1'b1;
         edge_flag <= 1'b0;
         wake_req  <= 1'b0;
      end else begin
         rx_prev <= rx_src;
         if (edge_en && rx_prev && !rx_src) begin
            edge_flag <= 1'b1;
         end else if (w1c_ok && pwdata[`UNBL_ST_EDGE]) begin
            edge_flag <= 1'b0;
         end
         wake_req <= edge_flag & rx_edge_irq_enable;
      end
   end
endmodule

// ===== sim/tb_top.sv
// Self-checking bench: registers, loop, single wire and stop handling.
`timescale 1ns/10ps
`include "unbl_map.vh"
module tb_top;
   localparam TXRX = 32'h0000_0060;
   localparam NINE = 32'h0000_0001;
   localparam LOOP = 32'h0000_0002;
   localparam RECEIVER_SOURCE_SELECT = 32'h0000_0004;
   reg         clk, sys_rst, psel, penable, pwrite, e;
   reg         mark, noise, pulse, nine, talk;
   reg  [7:0]  paddr;
   reg  [1:0]  stop_mode;
   reg  [31:0] pwdata, q, c1, c3, w;
   reg  [31:0] rd_q[$];
   reg  [8:0]  sr_q[$];
   integer     err_total, n_checks, seed, i, n;
   wire [31:0] prdata;
   wire        pready, pslverr, txd_out, txd_oe, rxd_release, wake_req;
   wire        node_tx, node_oe, node_ok;
   wire [8:0]  node_word;
   wire        txd_line = txd_oe ? txd_out : node_oe ? node_tx : noise;
   wire        rxd_in = rxd_release ? noise : node_tx & ~pulse;
   unbl_top unbl_top_inst (.clk(clk), .sys_rst(sys_rst), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .stop_mode(stop_mode), .rxd_in(rxd_in), .txd_in(txd_line),
      .txd_out(txd_out), .txd_oe(txd_oe), .rxd_release(rxd_release),
      .wake_req(wake_req));
   unbl_node #(.BIT(32)) unbl_node_inst (.clk(clk), .nine(nine),
      .talk(talk), .line_rx(txd_line), .line_tx(node_tx),
      .line_oe(node_oe), .rx_valid(node_ok), .rx_word(node_word));
   always #12.5 clk = ~clk;
   always @(posedge clk) noise <= ~noise;
   // ==========
   // Comparison, bus cycle and wait helpers.
   task chk(input [79:0] what, input [31:0] seen, input [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp) begin
            err_total = err_total + 1;
            $display("CHECK FAILED %0s exp %h seen %h", what, exp, seen);
         end
      end
   endtask
   task apb(input wd, input [7:0] a, input [31:0] d);
      integer t;
      begin
         psel <= 1'b1;
         pwrite <= wd;
         paddr <= a;
         pwdata <= d;
         @(posedge clk);
         penable <= 1'b1;
         t = 0;
         @(posedge clk);
         while (pready !== 1'b1 && t < 20) begin
            @(posedge clk);
            t = t + 1;
         end
         q = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         mark <= 1'b0;
         @(posedge clk);
      end
   endtask
   task rd_exp(input [7:0] a, input [31:0] x);
      begin
         rd_q.push_back(x);
         mark <= 1'b1;
         apb(1'b0, a, 32'h0000_0000);
      end
   endtask
   task xmit(input [31:0] x);
      begin
         sr_q.push_back(nine ? x[8:0] : {1'b0, x[7:0]});
         apb(1'b1, `UNBL_OFS_DATA, x & 32'h0000_00ff);
      end
   endtask
   task wait_rx;
      begin
         n = 0;
         q = 32'h0000_0000;
         while (q[`UNBL_ST_RXFULL] !== 1'b1 && n < 400) begin
            apb(1'b0, `UNBL_OFS_STATUS, 32'h0000_0000);
            n = n + 1;
         end
         if (n >= 400) chk("rxwait", 32'h0000_0000, 32'h0000_0001);
      end
   endtask
   task wait_ser;
      begin
         n = 0;
         while (sr_q.size() > 0 && n < 4000) begin
            @(posedge clk);
            n = n + 1;
         end
         if (n >= 4000) chk("serwait", 32'h0000_0000, 32'h0000_0001);
      end
   endtask
   task tally_and_finish;
      begin
         $display("Checks %0d mismatches %0d", n_checks, err_total);
         if (err_total == 0 && n_checks > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   // ==========
   // Monitor: compares each marked read and each node word with the oldest note.
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && mark)
         chk("read", prdata, rd_q.pop_front());
      if (node_ok === 1'b1)
         chk("line", {23'h00_0000, node_word}, sr_q.pop_front());
   end
   initial begin
      #1000000;
      err_total = err_total + 1;
      $display("Watchdog expired");
      tally_and_finish;
   end
   // ==========
   // Main sequence.
   initial begin
      clk = 1'b0;
      {sys_rst, talk} = 2'b11;
      {psel, penable, pwrite, e, mark, noise, pulse, nine} = 8'h00;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      stop_mode = 2'b00;
      seed = 32'ha8a3_747d;
      err_total = 0;
      n_checks = 0;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      rd_exp(`UNBL_OFS_CTRL1, 32'h0000_0000);
      rd_exp(`UNBL_OFS_CTRL3, 32'h0000_0000);
      rd_exp(`UNBL_OFS_BAUD, 32'h0000_0015);
      apb(1'b0, 8'h20, 32'h0000_0000);
      chk("unmapped", {31'h0000_0000, e}, 32'h0000_0001);
      apb(1'b1, `UNBL_OFS_BAUD, 32'h0000_0002);
      $display("Test registers done");
      for (i = 0; i < 5; i = i + 1) begin
         c1 = TXRX | LOOP | (i > 0 ? NINE : 0) | (i == 4 ? RECEIVER_SOURCE_SELECT : 0);
         c3 = (32'h0005_0110 >> (4 * i)) & 32'h0000_000f;
         nine <= c1[0];
         talk <= (i != 4);
         if (i != 2) apb(1'b1, `UNBL_OFS_CTRL3, c3);
         apb(1'b1, `UNBL_OFS_CTRL1, c1);
         w = $random(seed);
         w[8] = c3[0];
         xmit(w);
         wait_rx;
         if (c1[0]) rd_exp(`UNBL_OFS_CTRL3, c3 | {w[8], 1'b0});
         rd_exp(`UNBL_OFS_DATA, w & 32'h0000_00ff);
      end
      wait_ser;
      $display("Test loopback done");
      talk <= 1'b1;
      apb(1'b1, `UNBL_OFS_CTRL3, 32'h0000_0000);
      apb(1'b1, `UNBL_OFS_CTRL1, TXRX | NINE);
      w = $random(seed);
      unbl_node_inst.send(w[8:0]);
      wait_rx;
      rd_exp(`UNBL_OFS_CTRL3, {w[8], 1'b0});
      rd_exp(`UNBL_OFS_DATA, w & 32'h0000_00ff);
      n = 0;
      e = 1'b0;
      while (e !== 1'b1 && n < 6) begin
         w = $random(seed);
         sr_q.push_back({1'b0, w[7:0]});
         apb(1'b1, `UNBL_OFS_DATA, w & 32'h0000_00ff);
         n = n + 1;
      end
      void'(sr_q.pop_back());
      chk("accepted", n, 32'h0000_0004);
      wait_ser;
      apb(1'b1, `UNBL_OFS_CTRL1, TXRX | NINE | LOOP | RECEIVER_SOURCE_SELECT);
      w = $random(seed);
      sr_q.push_back(w[8:0]);
      unbl_node_inst.send(w[8:0]);
      wait_rx;
      rd_exp(`UNBL_OFS_CTRL3, {w[8], 1'b0});
      rd_exp(`UNBL_OFS_DATA, w & 32'h0000_00ff);
      wait_ser;
      $display("Test duplex and single wire done");
      nine <= 1'b0;
      apb(1'b1, `UNBL_OFS_CTRL1, TXRX);
      apb(1'b1, `UNBL_OFS_STATUS, 32'h0000_0008);
      apb(1'b1, `UNBL_OFS_CTRL3, 32'h0000_0008);
      chk("wake", {31'h0000_0000, wake_req}, 32'h0000_0000);
      stop_mode <= 2'b01;
      repeat (4) @(posedge clk);
      pulse <= 1'b1;
      repeat (4) @(posedge clk);
      pulse <= 1'b0;
      repeat (4) @(posedge clk);
      chk("wake", {31'h0000_0000, wake_req}, 32'h0000_0001);
      rd_exp(`UNBL_OFS_CTRL1, TXRX);
      stop_mode <= 2'b00;
      apb(1'b1, `UNBL_OFS_CTRL3, 32'h0000_0000);
      w = $random(seed);
      xmit(w);
      wait_ser;
      stop_mode <= 2'b10;
      repeat (3) @(posedge clk);
      stop_mode <= 2'b00;
      rd_exp(`UNBL_OFS_CTRL1, 32'h0000_0000);
      rd_exp(`UNBL_OFS_BAUD, 32'h0000_0015);
      $display("Test stop done");
      tally_and_finish;
   end
endmodule
bind unbl_top unbl_chk unbl_chk_inst (.clk(clk), .sys_rst(sys_rst),
   .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pwdata(pwdata), .pready(pready), .stop_mode(stop_mode),
   .txd_out(txd_out), .txd_oe(txd_oe), .rxd_release(rxd_release),
   .wake_req(wake_req));

// ===== sim/unbl_chk_sva.sv
// Checker for the serial port pins against its configuration.
`timescale 1ns/10ps
`include "unbl_map.vh"
module unbl_chk (
   input wire        clk,
   input wire        sys_rst,
   input wire [7:0]  paddr,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [31:0] pwdata,
   input wire        pready,
   input wire [1:0]  stop_mode,
   input wire        txd_out,
   input wire        txd_oe,
   input wire        rxd_release,
   input wire        wake_req
);
   // ==========
   // Shadow of the pin configuration, built from completed writes.
   reg       lp, rs, dr, ie;
   reg [1:0] st;
   wire      wr = psel & penable & pready & pwrite;
   always @(posedge clk) begin
      if (sys_rst | stop_mode[1]) begin
         lp <= 1'b0;
         rs <= 1'b0;
         dr <= 1'b0;
         ie <= 1'b0;
         st <= 2'b00;
      end else begin
         if (wr && paddr == `UNBL_OFS_CTRL1) begin
            lp <= pwdata[`UNBL_C1_LOOP];
            rs <= pwdata[`UNBL_C1_RECEIVER_SOURCE_SELECT];
         end
         if (wr && paddr == `UNBL_OFS_CTRL3) begin
            dr <= pwdata[`UNBL_C3_DIR];
            ie <= pwdata[`UNBL_C3_EDGEIE];
         end
         if (wr)
            st <= 2'b00;
         else if (st != 2'b11)
            st <= st + 2'b01;
      end
   end
   // ==========
   // Properties.
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_rel; st[1] |-> rxd_release == lp; endproperty
   property p_lpoe; st[1] && lp && !rs |-> txd_oe; endproperty
   property p_swin; st[1] && lp && rs && !dr |-> !txd_oe; endproperty
   property p_swout; st[1] && lp && rs && dr |-> txd_oe; endproperty
   property p_full; st[1] && !lp |-> txd_oe && !rxd_release; endproperty
   property p_frz; (stop_mode == 2'b01) [*3] |-> $stable(txd_out); endproperty
   property p_keep;
      st[1] && !wr && stop_mode == 2'b01 |=> $stable(rxd_release)
         && $stable(txd_oe);
   endproperty
   property p_deep;
      stop_mode[1] |=> txd_out && txd_oe && !rxd_release && !wake_req;
   endproperty
   property p_wake; wake_req |-> ie || $past(ie); endproperty
   a_rel: assert property (p_rel) else $error("rx pin release wrong");
   a_lpoe: assert property (p_lpoe) else $error("loop oe low");
   a_swin: assert property (p_swin) else $error("pin not freed");
   a_swout: assert property (p_swout) else $error("pin not driven");
   a_full: assert property (p_full) else $error("duplex pins wrong");
   a_frz: assert property (p_frz) else $error("line moved in stop");
   a_keep: assert property (p_keep) else $error("state lost in stop");
   a_deep: assert property (p_deep) else $error("deep stop kept state");
   a_wake: assert property (p_wake) else $error("wake while masked");
   c_sw: cover property (lp && rs && !dr && !txd_oe);
   c_wake: cover property ($rose(wake_req));
   c_stop: cover property ((stop_mode == 2'b01) [*3]);
endmodule

// ===== sim/unbl_node.sv
// Remote serial node that sends and hears characters on one line.
`timescale 1ns/10ps
module unbl_node #(
   parameter BIT = 32
) (
   input wire       clk,
   input wire       nine,
   input wire       talk,
   input wire       line_rx,
   output reg       line_tx,
   output wire      line_oe,
   output reg       rx_valid,
   output reg [8:0] rx_word
);
   // ==========
   // Sender: start bit, data first bit lowest, stop bit, idle high.
   assign line_oe = talk;
   task send(input [8:0] w);
      reg [10:0] f;
      integer    k;
      begin
         f = nine ? {1'b1, w, 1'b0} : {2'b11, w[7:0], 1'b0};
         for (k = 0; k < (nine ? 11 : 10); k = k + 1) begin
            line_tx <= f[k];
            repeat (BIT) @(posedge clk);
         end
      end
   endtask
   // ==========
   // Receiver: samples each bit in its middle.
   initial begin : rx_proc
      reg [10:0] f;
      integer    n;
      line_tx = 1'b1;
      rx_valid = 1'b0;
      rx_word = 9'h000;
      forever begin
         @(posedge clk);
         if (line_rx === 1'b0) begin
            repeat (BIT / 2) @(posedge clk);
            for (n = 0; n < (nine ? 11 : 10); n = n + 1) begin
               f[n] = line_rx;
               if (n < (nine ? 10 : 9))
                  repeat (BIT) @(posedge clk);
            end
            rx_word <= nine ? f[9:1] : {1'b0, f[8:1]};
            rx_valid <= 1'b1;
            @(posedge clk);
            rx_valid <= 1'b0;
         end
      end
   end
endmodule
